/* File: shared/mrs_pkg.sv */
`default_nettype none
package mrs_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 50;                    // System clock rate
   localparam int DIP_MIN_US = 1000;               // Dip must last longer than this to reset
   localparam int DIP_CYC_DEF = DIP_MIN_US * CLK_MHZ;
   localparam int POST_RELEASE_US = 100;           // Delay after reset release
   localparam int POST_RELEASE_CYC_DEF = POST_RELEASE_US * CLK_MHZ;
   localparam int CNT_W = 17;                      // Wide enough for both counts

   // ---------------------------------------------------------------
   // Widths and reset images
   // ---------------------------------------------------------------
   localparam int IRQ_N = 8;                       // Interrupt sources
   localparam int VEC_W = 3;                       // Vector index width
   localparam int PC_W = 13;                       // Program counter width
   localparam int SP_W = 3;                        // Stack pointer width
   localparam int PORT_W = 8;                      // Port width
   localparam int EV_N = 4;                        // Event status bits
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [SP_W-1:0] SP_TOP = 3'h7;      // Top of hardware stack
   localparam logic [SP_W-1:0] SP_CLEAR = 3'h0;    // Cleared stack pointer
   localparam logic [PORT_W-1:0] PORT_RESET = 8'hff;

   // ---------------------------------------------------------------
   // Register map and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_IRQ_FLAG = 8'h08;    // irq_control_a flags
   localparam logic [7:0] OFF_IRQ_EN = 8'h0c;      // irq_control_b enables
   localparam logic [7:0] OFF_CMD = 8'h10;
   localparam logic [7:0] OFF_EV_ST = 8'h14;
   localparam logic [7:0] OFF_EV_MASK = 8'h18;
   localparam int CTRL_DIP_EN = 0;
   localparam int CTRL_DIP_SEL = 1;                // Two bits
   localparam int CTRL_GIE = 3;
   localparam int CTRL_TIMER = 4;
   localparam int STAT_WDT = 0;
   localparam int STAT_PD = 1;
   localparam int STAT_ST = 2;                     // Two bits
   localparam int CMD_SLEEP = 0;
   localparam int EV_PIN = 0;
   localparam int EV_DIP = 1;
   localparam int EV_WDT = 2;
   localparam int EV_WAKE = 3;
   localparam logic DIP_EN_RST = 1'b1;
   localparam logic [1:0] DIP_SEL_RST = 2'h0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_HOLD = 2'h0, ST_DELAY = 2'h1, ST_RUN = 2'h3, ST_SLEEP = 2'h2
   } mrs_st_type;
   typedef enum logic [1:0] {
      KIND_NONE = 2'h0, KIND_FULL = 2'h1, KIND_PCSP = 2'h2
   } mrs_kind_type;
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [SP_W-1:0] sp;
      logic [PORT_W-1:0] port_data;
      logic [PORT_W-1:0] port_dir;
   } mrs_init_type;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } mrs_apb_req_type;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } mrs_apb_rsp_type;
   typedef struct packed {
      mrs_st_type st;
      logic [1:0] pin_sync;
      logic [CNT_W-1:0] dip_cnt;
      logic [CNT_W-1:0] dly_cnt;
      logic wdt_flag;
      logic pd_flag;
      mrs_kind_type kind;
      logic dip_en;
      logic [1:0] dip_sel;
      logic gie;
      logic timer_on;
      logic [IRQ_N-1:0] irq_flag;
      logic [IRQ_N-1:0] irq_en;
      logic [EV_N-1:0] ev_st;
      logic [EV_N-1:0] ev_mask;
      logic [31:0] prdata;
      logic pslverr;
      logic push;
      logic [VEC_W-1:0] vec;
      logic [PC_W-1:0] push_pc;
      mrs_init_type init;
   } mrs_state_type;
   localparam mrs_init_type INIT_FULL = '{pc: PC_RESET, sp: SP_TOP,
      port_data: PORT_RESET, port_dir: PORT_RESET};
   localparam mrs_state_type STATE_RESET = '{st: ST_HOLD, kind: KIND_FULL,
      dip_en: DIP_EN_RST, dip_sel: DIP_SEL_RST, init: INIT_FULL, default: '0};
endpackage : mrs_pkg
`default_nettype wire

/* File: hw/mrs_reset_sequencer.sv */
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_sequencer #(
   parameter logic [mrs_pkg::CNT_W-1:0] DIP_CYC = mrs_pkg::CNT_W'(mrs_pkg::DIP_CYC_DEF),
   parameter logic [mrs_pkg::CNT_W-1:0] DLY_CYC =
      mrs_pkg::CNT_W'(mrs_pkg::POST_RELEASE_CYC_DEF)
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire mrs_pkg::mrs_apb_req_type apb_req,
   output mrs_pkg::mrs_apb_rsp_type apb_rsp,
   input wire logic external_clear_pin_n,
   input wire logic supply_dip,
   input wire logic watchdog_overflow,
   input wire logic [mrs_pkg::IRQ_N-1:0] irq_request,
   input wire logic [mrs_pkg::PC_W-1:0] core_pc,
   input wire logic stack_full,
   output logic core_run,
   output mrs_pkg::mrs_kind_type reset_kind,
   output mrs_pkg::mrs_init_type init_image,
   output logic watchdog_clear,
   output logic timer_enable,
   output logic prescaler_clear,
   output logic [1:0] supply_dip_threshold,
   output logic [1:0] low_voltage_detect_threshold,
   output logic watchdog_expiry_flag,
   output logic power_down_flag,
   output logic irq_entry,
   output logic [mrs_pkg::VEC_W-1:0] irq_vector,
   output logic [mrs_pkg::PC_W-1:0] stack_push_pc,
   output logic irq
);
   import mrs_pkg::*;

   // ---------------------------------------------------------------
   // State and combinational helpers
   // ---------------------------------------------------------------
   mrs_state_type s_q;            // All registered state
   mrs_state_type s_d;            // Next value of the state
   logic pin_low;                 // Synchronised pin is asserted
   logic dip_qual;                // Dip has lasted past the minimum
   logic apb_setup;               // Setup phase of an APB transfer
   logic apb_wr;                  // Write taking effect this edge
   logic sleep_cmd;               // Software asks for power down
   logic [IRQ_N-1:0] pend;        // Enabled pending requests
   logic [IRQ_N-1:0] irq_clr;     // Flags being cleared this cycle
   logic [IRQ_N-1:0] flag_keep;   // Flags that must survive
   logic [EV_N-1:0] ev_clr;       // Event bits cleared by software
   logic [EV_N-1:0] ev_set;       // Event bits raised by hardware
   logic [VEC_W-1:0] low_idx;     // Lowest pending source

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   // One process computes every field; the register bus, the reset
   // sequencing and the interrupt entry all meet here.
   always_comb begin
      // Defaults: every field holds, every strobe is low
      s_d = s_q;
      ev_clr = '0;
      ev_set = '0;
      irq_clr = '0;
      sleep_cmd = 1'b0;
      low_idx = '0;
      s_d.push = 1'b0;
      // Pin passes two flops; only the second one is read
      s_d.pin_sync = {s_q.pin_sync[0], external_clear_pin_n};
      pin_low = ~s_q.pin_sync[1];
      // Reading the first stage would let metastability through
      // Count consecutive dip cycles, saturating at the limit
      // Saturation keeps a long dip qualified, so the core stays held
      // A disabled dip reset also keeps the counter at zero
      if (supply_dip && s_q.dip_en) begin
         if (s_q.dip_cnt != DIP_CYC) begin
            s_d.dip_cnt = CNT_W'(s_q.dip_cnt + 1'b1);
         end
      end else begin
         s_d.dip_cnt = '0;
      end
      // Dip must be seen for DIP_CYC+1 cycles, strictly over the minimum
      dip_qual = s_q.dip_en & supply_dip & (s_q.dip_cnt == DIP_CYC);
      // Disabled flags stay set and simply wait to be taken
      pend = s_q.irq_flag & s_q.irq_en;
      // Lowest index wins when several sources are pending
      for (int i = IRQ_N - 1; i >= 0; i--) begin
         if (pend[i]) begin
            low_idx = VEC_W'(i);
         end
      end

      // Register bus: read data captured in setup, answered in access
      // Capture at setup keeps the decode off the access path; the
      // price is that a read shows the state of the setup cycle
      apb_setup = apb_req.psel & ~apb_req.penable;
      apb_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
      if (apb_setup) begin
         s_d.prdata = '0;
         s_d.pslverr = 1'b0;
         case (apb_req.paddr)
            OFF_CTRL: begin
               s_d.prdata[CTRL_DIP_EN] = s_q.dip_en;
               s_d.prdata[CTRL_DIP_SEL +: 2] = s_q.dip_sel;
               s_d.prdata[CTRL_GIE] = s_q.gie;
               s_d.prdata[CTRL_TIMER] = s_q.timer_on;
            end
            OFF_STATUS: begin
               s_d.prdata[STAT_WDT] = s_q.wdt_flag;
               s_d.prdata[STAT_PD] = s_q.pd_flag;
               s_d.prdata[STAT_ST +: 2] = s_q.st;
            end
            OFF_IRQ_FLAG: s_d.prdata[IRQ_N-1:0] = s_q.irq_flag;
            OFF_IRQ_EN: s_d.prdata[IRQ_N-1:0] = s_q.irq_en;
            OFF_CMD: s_d.prdata = '0;
            OFF_EV_ST: s_d.prdata[EV_N-1:0] = s_q.ev_st;
            OFF_EV_MASK: s_d.prdata[EV_N-1:0] = s_q.ev_mask;
            default: s_d.pslverr = 1'b1;     // Unmapped address
         endcase
      end
      // Writes land on the access edge; pready is always high
      if (apb_wr) begin
         case (apb_req.paddr)
            OFF_CTRL: begin
               // Threshold code also picks the paired detect level
               s_d.dip_en = apb_req.pwdata[CTRL_DIP_EN];
               s_d.dip_sel = apb_req.pwdata[CTRL_DIP_SEL +: 2];
               s_d.gie = apb_req.pwdata[CTRL_GIE];
               s_d.timer_on = apb_req.pwdata[CTRL_TIMER];
            end
            OFF_STATUS: begin
               // Write one clears; a same-cycle set below still wins
               if (apb_req.pwdata[STAT_WDT]) begin
                  s_d.wdt_flag = 1'b0;
               end
               if (apb_req.pwdata[STAT_PD]) begin
                  s_d.pd_flag = 1'b0;
               end
            end
            OFF_IRQ_FLAG: irq_clr = apb_req.pwdata[IRQ_N-1:0];
            OFF_IRQ_EN: s_d.irq_en = apb_req.pwdata[IRQ_N-1:0];
            OFF_CMD: sleep_cmd = apb_req.pwdata[CMD_SLEEP];
            OFF_EV_ST: ev_clr = apb_req.pwdata[EV_N-1:0];
            OFF_EV_MASK: s_d.ev_mask = apb_req.pwdata[EV_N-1:0];
            default: s_d.ev_mask = s_q.ev_mask;   // Ignored
         endcase
      end

      // Reset sequencing; pin and qualified dip outrank everything
      // Event bits are raised on every cycle the cause is active
      if (pin_low || dip_qual) begin
         s_d.st = ST_HOLD;
         s_d.kind = KIND_FULL;
         s_d.init = INIT_FULL;
         s_d.dly_cnt = '0;
         ev_set[EV_PIN] = pin_low;
         ev_set[EV_DIP] = dip_qual;
      end else begin
         case (s_q.st)
            ST_HOLD: begin
               // Release seen: start the post-release delay
               // Here the pin is high and no dip qualifies
               s_d.st = ST_DELAY;
               s_d.dly_cnt = '0;
            end
            ST_DELAY: begin
               // Core stays held until the counter runs out
               // Counting 0 to DLY_CYC-1 gives DLY_CYC held cycles
               if (s_q.dly_cnt == CNT_W'(DLY_CYC - 1'b1)) begin
                  s_d.st = ST_RUN;
               end else begin
                  s_d.dly_cnt = CNT_W'(s_q.dly_cnt + 1'b1);
               end
            end
            ST_RUN: begin
               // Watchdog first, then sleep request, then entry
               if (watchdog_overflow) begin
                  // Full image as a pin reset, but straight into the delay, plus the expiry flag
                  s_d.st = ST_DELAY;
                  s_d.kind = KIND_FULL;
                  s_d.init = INIT_FULL;
                  s_d.dly_cnt = '0;
                  s_d.wdt_flag = 1'b1;
                  ev_set[EV_WDT] = 1'b1;
               end else if (sleep_cmd) begin
                  s_d.st = ST_SLEEP;
                  s_d.pd_flag = 1'b1;
               end else if (s_q.gie && (|pend) && !stack_full) begin
                  // Only the program counter goes onto the stack
                  // Status is not saved; software must keep it
                  // A full stack refuses entry and the flag waits
                  s_d.push = 1'b1;
                  s_d.push_pc = core_pc;
                  s_d.vec = low_idx;
                  s_d.gie = 1'b0;
                  irq_clr[low_idx] = 1'b1;
               end
            end
            ST_SLEEP: begin
               if (watchdog_overflow) begin
                  // Everything else keeps its value
                  // Ports, enables and flags survive this reset
                  s_d.st = ST_DELAY;
                  s_d.kind = KIND_PCSP;
                  s_d.init.pc = PC_RESET;
                  s_d.init.sp = SP_CLEAR;
                  s_d.dly_cnt = '0;
                  s_d.wdt_flag = 1'b1;
                  s_d.pd_flag = 1'b1;
                  ev_set[EV_WDT] = 1'b1;
               end else if (|s_q.irq_flag) begin
                  // Any raised request wakes, enabled or not
                  s_d.st = ST_RUN;
                  ev_set[EV_WAKE] = 1'b1;
               end
            end
            default: s_d.st = ST_HOLD;
         endcase
      end

      // Held full reset: interrupts off, timer off
      // Only while held: a sleeping core keeps its enables, so
      // interrupts enabled before it sleeps are still taken once it wakes
      if (s_d.kind == KIND_FULL && (s_d.st == ST_HOLD || s_d.st == ST_DELAY)) begin
         s_d.irq_en = '0;
         s_d.gie = 1'b0;
         s_d.timer_on = 1'b0;
      end
      // Sticky flags: a new request beats a clear in the same cycle
      // Service clears only the flag of the source being taken
      flag_keep = s_q.irq_flag & ~irq_clr;
      s_d.irq_flag = flag_keep | irq_request;
      s_d.ev_st = (s_q.ev_st & ~ev_clr) | ev_set;
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Power-on image: flags zero, full reset kind, ports all ones
   // Constants only in the reset branch, so nothing races it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= STATE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Outputs come straight from state registers, except the tied-high
   // pready and the decoded run, clear and interrupt levels
   assign apb_rsp.prdata = s_q.prdata;
   assign apb_rsp.pready = 1'b1;              // Zero wait states
   assign apb_rsp.pslverr = s_q.pslverr;
   assign core_run = (s_q.st == ST_RUN);
   assign reset_kind = s_q.kind;
   assign init_image = s_q.init;
   // Watchdog held clear while the core is held; counts once released
   assign watchdog_clear = (s_q.st == ST_HOLD) || (s_q.st == ST_DELAY);
   assign prescaler_clear = watchdog_clear;
   assign timer_enable = s_q.timer_on;
   assign supply_dip_threshold = s_q.dip_sel;
   assign low_voltage_detect_threshold = s_q.dip_sel;
   assign watchdog_expiry_flag = s_q.wdt_flag;
   assign power_down_flag = s_q.pd_flag;
   assign irq_entry = s_q.push;
   assign irq_vector = s_q.vec;
   assign stack_push_pc = s_q.push_pc;
   assign irq = |(s_q.ev_st & s_q.ev_mask);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // Checks sleep through power-on reset; its image is constant

   // Neither pin nor dip nor watchdog is acting this cycle
   logic quiet;
   assign quiet = !pin_low && !dip_qual && !watchdog_overflow;

   sequence s_wdt_in_sleep;
      (s_q.st == ST_SLEEP) && watchdog_overflow && !pin_low && !dip_qual;
   endsequence
   sequence s_pcsp_image;
      s_q.wdt_flag && s_q.pd_flag && (s_q.kind == KIND_PCSP) &&
         (s_q.init.pc == PC_RESET) && (s_q.init.sp == SP_CLEAR) &&
         (s_q.st == ST_DELAY);
   endsequence

   chk_flag_sticky: assert property (1'b1 |=>
      ((s_q.irq_flag & $past(flag_keep)) == $past(flag_keep)))
      else $error("interrupt flag lost without clear or service");
   chk_sleep_wake: assert property (
      (s_q.st == ST_SLEEP) && (|s_q.irq_flag) && quiet |=> core_run)
      else $error("pending request did not wake from power down");
   chk_push_pc: assert property (
      irq_entry |-> (stack_push_pc == $past(core_pc)) && !s_q.gie)
      else $error("interrupt entry pushed wrong value");
   chk_full_image: assert property (
      (s_q.kind == KIND_FULL) && !core_run |->
         (s_q.init.pc == PC_RESET) && (s_q.init.sp == SP_TOP) &&
         (s_q.init.port_dir == PORT_RESET) && (s_q.init.port_data == PORT_RESET))
      else $error("full reset image wrong");
   chk_release_wait: assert property (
      core_run && ($past(s_q.st) == ST_DELAY) |->
         ($past(s_q.dly_cnt) == CNT_W'(DLY_CYC - 1'b1)))
      else $error("core released before delay expired");
   chk_pin_hold: assert property (
      !s_q.pin_sync[1] |=> (s_q.st == ST_HOLD) && (s_q.kind == KIND_FULL) && !core_run)
      else $error("pin reset did not hold the core");
   chk_dip_filter: assert property (
      (s_q.st == ST_HOLD) && ($past(s_q.st) != ST_HOLD) && $past(s_q.pin_sync[1]) |->
         ($past(s_q.dip_cnt) == DIP_CYC))
      else $error("short dip caused a reset");
   chk_dip_disabled: assert property (
      !s_q.dip_en && s_q.pin_sync[1] && (s_q.st != ST_HOLD) |=> (s_q.st != ST_HOLD))
      else $error("disabled dip reset acted");
   chk_wdt_run: assert property (
      core_run && watchdog_overflow && !pin_low && !dip_qual |=>
         s_q.wdt_flag && (s_q.kind == KIND_FULL) && (s_q.st == ST_DELAY) &&
         (s_q.pd_flag == $past(s_q.pd_flag)))
      else $error("running watchdog expiry handled wrongly");
   chk_wdt_sleep: assert property (
      s_wdt_in_sleep |=> s_pcsp_image)
      else $error("sleeping watchdog expiry handled wrongly");
   chk_irq_off: assert property (
      (s_q.kind == KIND_FULL) && watchdog_clear |->
         (s_q.irq_en == '0) && !s_q.gie && !timer_enable && prescaler_clear)
      else $error("interrupts or timer live during reset");
   chk_wdt_clear: assert property (
      (s_q.st == ST_DELAY) ##1 core_run |-> !watchdog_clear && $past(watchdog_clear))
      else $error("watchdog not cleared then released");
   chk_pair_thresh: assert property (
      apb_wr && (apb_req.paddr == OFF_CTRL) |=>
         (low_voltage_detect_threshold == $past(apb_req.pwdata[CTRL_DIP_SEL +: 2])) &&
         (supply_dip_threshold == low_voltage_detect_threshold))
      else $error("thresholds not paired");

   // ---------------------------------------------------------------
   // Refusals and untouched flags
   // ---------------------------------------------------------------
   // A full stack must hold back entry on the next cycle
   chk_stack_block: assert property (
      stack_full |=> !irq_entry)
      else $error("interrupt taken with a full stack");
   // Pin and dip resets leave both cause flags as they were
   chk_reset_flags: assert property (
      (pin_low || dip_qual) && !apb_wr |=>
         $stable(watchdog_expiry_flag) && $stable(power_down_flag))
      else $error("pin or dip reset changed the cause flags");
endmodule : mrs_reset_sequencer
`default_nettype wire

/* File: verif/mrs_ext_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Outside reset sources: pin circuit, supply monitor, watchdog
// ---------------------------------------------------------------
module mrs_ext_model (
   input wire logic clk,
   output logic external_clear_pin_n,
   output logic supply_dip,
   output logic watchdog_overflow
);
   // Idle: pin pulled up, supply good, watchdog quiet
   initial begin
      external_clear_pin_n = 1'b1;
      supply_dip = 1'b0;
      watchdog_overflow = 1'b0;
   end
   // Pin pulled low for n cycles while the core runs; the pull-up restores it
   task automatic press_pin(input int n);
      @(posedge clk);
      external_clear_pin_n <= 1'b0;
      repeat (n) @(posedge clk);
      external_clear_pin_n <= 1'b1;
   endtask : press_pin
   // Low-supply indication held for exactly n cycles
   task automatic dip_for(input int n);
      @(posedge clk);
      supply_dip <= 1'b1;
      repeat (n) @(posedge clk);
      supply_dip <= 1'b0;
   endtask : dip_for
   // One-cycle expiry pulse, as the counter gives on overflow
   task automatic wdt_tick;
      @(posedge clk);
      watchdog_overflow <= 1'b1;
      @(posedge clk);
      watchdog_overflow <= 1'b0;
   endtask : wdt_tick
endmodule : mrs_ext_model
`default_nettype wire

/* File: verif/mrs_reset_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_sequencer_tb;
   import mrs_pkg::*;
   // ---------------------------------------------------------------
   // Signals; short counts keep the run brief
   // ---------------------------------------------------------------
   localparam int DLY_N = 8;
   logic clk, arst_n, pin_n, dip, wdt, stack_full, core_run, wd_clr, tmr, psc;
   logic wdt_flag, pd_flag, irq_entry, irq, err;
   mrs_apb_req_type apb_req;
   mrs_apb_rsp_type apb_rsp;
   mrs_kind_type kind;
   mrs_init_type init_image;
   logic [IRQ_N-1:0] irq_request;
   logic [PC_W-1:0] core_pc, push_pc;
   logic [VEC_W-1:0] vec;
   logic [1:0] dip_thr, lvd_thr;
   logic [31:0] rd, ent_info;
   int fail_count, compares, n, ent_cnt;
   mrs_reset_sequencer #(.DIP_CYC(17'd20), .DLY_CYC(17'd8)) dut (.clk(clk), .arst_n(arst_n),
      .apb_req(apb_req), .apb_rsp(apb_rsp), .external_clear_pin_n(pin_n), .supply_dip(dip),
      .watchdog_overflow(wdt), .irq_request(irq_request), .core_pc(core_pc),
      .stack_full(stack_full), .core_run(core_run), .reset_kind(kind),
      .init_image(init_image), .watchdog_clear(wd_clr), .timer_enable(tmr),
      .prescaler_clear(psc), .supply_dip_threshold(dip_thr),
      .low_voltage_detect_threshold(lvd_thr), .watchdog_expiry_flag(wdt_flag),
      .power_down_flag(pd_flag), .irq_entry(irq_entry), .irq_vector(vec),
      .stack_push_pc(push_pc), .irq(irq));
   mrs_ext_model ext (.clk(clk), .external_clear_pin_n(pin_n), .supply_dip(dip),
      .watchdog_overflow(wdt));
   // Free-running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Entry pulses last one cycle, so they are caught at every edge
   always @(posedge clk) begin
      if (irq_entry === 1'b1) begin
         ent_cnt++;
         ent_info = {16'h0, vec, push_pc};
      end
   end
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Let k edges pass, then look once their updates have landed
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   // One APB transfer; waits for pready, the watchdog bounds it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc
   // Count cycles until the core may run again, bounded
   task automatic wait_run;
      n = 0;
      while (core_run !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
   endtask : wait_run
   task automatic pulse_irq(input int i);
      @(posedge clk);
      irq_request[i] <= 1'b1;
      @(posedge clk);
      irq_request <= '0;
   endtask : pulse_irq
   task automatic done(input string s);
      $display("test %s done: compares %0d mismatches %0d", s, compares, fail_count);
   endtask : done
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      apb_req = '0;
      irq_request = '0;
      core_pc = 13'h0abc;
      stack_full = 1'b0;
      tick(2);
      chk(init_image, {PC_RESET, SP_TOP, PORT_RESET, PORT_RESET});
      chk({core_run, wd_clr, tmr, wdt_flag, pd_flag}, 32'h8);
      @(posedge clk);
      arst_n <= 1'b1;
      wait_run();
      chk(n, DLY_N + 3);
      chk(wd_clr, 1'b0);
      done("power_on");
      apb(1'b1, OFF_IRQ_EN, 32'h4);
      pulse_irq(2);
      tick(3);
      rdc(OFF_IRQ_FLAG, 32'h4);
      apb(1'b1, OFF_CTRL, 32'h1d);
      tick(3);
      chk({ent_cnt[7:0], ent_info[15:0]}, {8'h1, 3'h2, 13'h0abc});
      rdc(OFF_IRQ_FLAG, 32'h0);
      rdc(OFF_CTRL, 32'h15);
      chk({dip_thr, lvd_thr, tmr}, 5'b10101);
      done("interrupt_entry");
      ext.wdt_tick();
      #1;
      chk({core_run, kind, wdt_flag, pd_flag, tmr, wd_clr, psc}, 8'b00110011);
      wait_run();
      chk(n, DLY_N);
      rdc(OFF_IRQ_EN, 32'h0);
      done("watchdog_run");
      apb(1'b1, OFF_CMD, 32'h1);
      tick(2);
      chk(pd_flag, 1'b1);
      ext.wdt_tick();
      #1;
      chk({kind, wdt_flag, pd_flag}, 4'b1011);
      chk(init_image, {PC_RESET, SP_CLEAR, PORT_RESET, PORT_RESET});
      tick(DLY_N + 2);
      chk(core_run, 1'b1);
      done("watchdog_sleep");
      ext.press_pin(4);
      tick(1);
      chk(core_run, 1'b0);
      wait_run();
      chk(n, DLY_N + 2);
      rdc(OFF_STATUS, 32'hf);
      done("pin");
      apb(1'b1, OFF_EV_MASK, 32'h4);
      tick(1);
      chk(irq, 1'b1);
      apb(1'b1, OFF_EV_ST, 32'hf);
      tick(1);
      chk(irq, 1'b0);
      apb(1'b1, OFF_STATUS, 32'h3);
      rdc(OFF_STATUS, 32'hc);
      done("events");
      ext.dip_for(20);
      tick(3);
      chk(core_run, 1'b1);
      ext.dip_for(22);
      #1;
      chk(core_run, 1'b0);
      tick(DLY_N + 4);
      rdc(OFF_STATUS, 32'hc);
      apb(1'b1, OFF_CTRL, 32'h4);
      ext.dip_for(22);
      tick(2);
      chk(core_run, 1'b1);
      done("supply_dip");
      apb(1'b1, OFF_CMD, 32'h1);
      tick(2);
      chk(pd_flag, 1'b1);
      pulse_irq(5);
      tick(2);
      chk(core_run, 1'b1);
      rdc(OFF_IRQ_FLAG, 32'h20);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      done("wake_and_unmapped");
      stack_full <= 1'b1;
      apb(1'b1, OFF_IRQ_EN, 32'h20);
      apb(1'b1, OFF_CTRL, 32'h8);
      tick(3);
      rdc(OFF_IRQ_FLAG, 32'h20);
      chk(ent_cnt, 1);
      stack_full <= 1'b0;
      tick(3);
      chk({ent_cnt[7:0], ent_info[15:0]}, {8'h2, 3'h5, 13'h0abc});
      done("stack_full");
      report_and_stop();
   end
   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule : mrs_reset_sequencer_tb
`default_nettype wire
